// ==== verilog/ccrsm_pkg.sv ====
// Purpose: Shared constants and decode for the core clock ratio strap mux
// Assumes: Ratio code order is {local_irq1, local_irq0, addr20_mask, ignore_numeric_error}
// Notes: Register map belongs to the system-side controller
package ccrsm_pkg;
    // Ratio code width and bit positions
    localparam int CODE_W = 4;
    localparam int CODE_LINT1_BIT = 3;
    localparam int CODE_LINT0_BIT = 2;
    localparam int CODE_ADDR20_MASK_PIN_BIT = 1;
    localparam int CODE_IGNORE_NUMERIC_ERROR_PIN_BIT = 0;

    // Codes of note
    localparam logic [3:0] CODE_HALF = 4'h0;
    localparam logic [3:0] CODE_QUARTER = 4'h2;
    localparam logic [3:0] CODE_TWO_NINTHS = 4'h6;

    // APB register offsets
    localparam int ADDR_W = 8;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_HOLD = 8'h08;
    localparam logic [7:0] REG_GAP = 8'h0c;

    // Field positions
    localparam int CTRL_CODE_LSB = 0;
    localparam int CTRL_GO_BIT = 16;
    localparam int STAT_CODE_LSB = 0;
    localparam int STAT_RST_BIT = 8;
    localparam int STAT_CRST_BIT = 9;
    localparam int STAT_BUSY_BIT = 10;
    localparam int STAT_BAD_BIT = 16;
    localparam int CNT_W = 16;

    // Values after reset
    localparam logic [3:0] CTRL_CODE_RST = CODE_QUARTER;
    localparam logic [15:0] HOLD_RST = 16'h0040;
    localparam logic [15:0] GAP_RST = 16'h0008;

    // Multiplier as {numerator, denominator}; zero marks a reserved code
    function automatic logic [7:0] ccrsm_mult(input logic [3:0] code);
        logic [7:0] m;
        m = 8'h00;
        case (code)
            4'h0: m = 8'h12;
            4'h1: m = 8'h13;
            4'h2: m = 8'h14;
            4'h3: m = 8'h15;
            4'h4: m = 8'h25;
            4'h5: m = 8'h27;
            4'h6: m = 8'h29;
            4'h7: m = 8'h2b;
            4'h8: m = 8'h16;
            4'h9: m = 8'h17;
            4'ha: m = 8'h18;
            4'hc: m = 8'h2d;
            4'hd: m = 8'h2f;
            4'he: m = 8'h23;
            default: m = 8'h00;
        endcase
        return m;
    endfunction : ccrsm_mult

    // Codes validated for running operation
    function automatic logic ccrsm_supported(input logic [3:0] code);
        return (code == CODE_QUARTER) || (code == CODE_TWO_NINTHS);
    endfunction : ccrsm_supported
endpackage : ccrsm_pkg

// ==== verilog/ccrsm_link_if.sv ====
// Purpose: Board-level link between system reset/mux logic and the processor
// Assumes: Both ends run from the same bus clock
// Notes: All signals are one-way, system to processor
`timescale 1ns/10ps
interface ccrsm_link_if;
    // Resets, active low
    logic sys_reset_n;
    logic cmos_reset_n;
    // Shared ratio pins
    logic addr20_mask_pin;
    logic ignore_numeric_error_pin;
    logic local_irq1_pin;
    logic local_irq0_pin;

    // System side drives everything
    modport host (
        output sys_reset_n, cmos_reset_n, addr20_mask_pin,
        output ignore_numeric_error_pin, local_irq1_pin, local_irq0_pin
    );
    // Processor side only listens
    modport dev (
        input sys_reset_n, cmos_reset_n, addr20_mask_pin,
        input ignore_numeric_error_pin, local_irq1_pin, local_irq0_pin
    );
endinterface : ccrsm_link_if

// ==== verilog/ccrsm_sync.sv ====
// Purpose: Two-flop synchroniser for a group of pin levels
// Assumes: Each bit is a slow level, not a coherent bus
// Notes: First stage is read only by the second
`timescale 1ns/10ps
module ccrsm_sync #(
    parameter int W = 4
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Level in and out
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r; // First stage
    logic [W-1:0] q_r; // Second stage

    // Two stages on the rising edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= '0;
            q_r <= '0;
        end else begin
            meta_r <= d;
            q_r <= meta_r;
        end
    end

    assign q = q_r;
endmodule : ccrsm_sync

// ==== verilog/ccrsm_dev.sv ====
// Purpose: Processor end: captures the core clock ratio at reset release
// Assumes: Link driven by the system end on the same bus clock
// Notes: Multiplier stays fixed until the next system reset
`timescale 1ns/10ps
module ccrsm_dev
    import ccrsm_pkg::*;
(
    // Bus clock and power-on reset
    input wire logic pclk,
    input wire logic presetn,
    // Link to the system end
    ccrsm_link_if.dev link,
    // Core clock configuration out
    output logic [3:0] core_ratio_code,
    output logic [3:0] core_mult_num,
    output logic [3:0] core_mult_den,
    output logic core_ratio_supported,
    output logic core_ratio_valid,
    output logic core_in_reset
);
    logic [4:0] pin_s; // Synchronised {reset, ratio pins}
    logic rst_s; // Synchronised system reset, active low
    logic rst_d_r; // Previous reset level for edge find
    logic [7:0] mult_w; // Multiplier decoded from the synchronised pins
    logic [3:0] code_r; // Captured ratio code
    logic [3:0] num_r; // Multiplier numerator
    logic [3:0] den_r; // Multiplier denominator
    logic sup_r; // Code is a validated one
    logic valid_r; // Capture done since last reset
    logic inrst_r; // Core held in reset

    // Reset and pins share one synchroniser so they stay aligned
    ccrsm_sync #(
        .W(5)
    ) u_pin_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d({link.sys_reset_n, link.local_irq1_pin, link.local_irq0_pin,
            link.addr20_mask_pin, link.ignore_numeric_error_pin}),
        .q(pin_s)
    );
    assign rst_s = pin_s[4];
    // Decode once; the capture takes both halves
    assign mult_w = ccrsm_mult(pin_s[3:0]);

    // Remember reset level for release detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_d_r <= 1'b0;
        end else begin
            rst_d_r <= rst_s;
        end
    end

    // Capture the pins on release and hold until next reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            code_r <= CODE_HALF;
            num_r <= 4'h0;
            den_r <= 4'h0;
            sup_r <= 1'b0;
        end else if (rst_s && !rst_d_r) begin
            // Release edge: sample pins once
            code_r <= pin_s[3:0];
            num_r <= mult_w[7:4];
            den_r <= mult_w[3:0];
            sup_r <= ccrsm_supported(pin_s[3:0]);
        end
    end

    // Valid from release until reset asserts again
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            valid_r <= 1'b0;
            inrst_r <= 1'b1;
        end else begin
            inrst_r <= !rst_s;
            if (!rst_s) begin
                valid_r <= 1'b0;
            end else if (!rst_d_r) begin
                valid_r <= 1'b1;
            end
        end
    end

    assign core_ratio_code = code_r;
    assign core_mult_num = num_r;
    assign core_mult_den = den_r;
    assign core_ratio_supported = sup_r;
    assign core_ratio_valid = valid_r;
    assign core_in_reset = inrst_r;
endmodule : ccrsm_dev

// ==== verilog/ccrsm_host.sv ====
// Purpose: System end: reset sequencer and ratio pin multiplexer
// Assumes: APB master on pclk; compatibility inputs are asynchronous
// Notes: Ratio code only reaches the pins inside a reset sequence
//
// Functional notes
// - Processor times everything on rising bus clock
// - Ratio code on four pins during reset
// - Pin order selects the PLL multiplier
// - Drive only validated ratio codes
// - Bus clock frequency stays constant
// - Never change code during normal operation
// - Change ratio only while reset asserted
// - CMOS reset steers the pin multiplexer
// - Default levels give a safe ratio
// - Ignore compatibility inputs while code driven
// - Synchronise ratio pins to bus clock
// - All processors share one ratio setting
`timescale 1ns/10ps
module ccrsm_host
    import ccrsm_pkg::*;
(
    // Bus clock and power-on reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Compatibility signals from the chipset
    input wire logic compat_addr20_mask,
    input wire logic compat_ignore_numeric_error,
    input wire logic compat_local_irq1,
    input wire logic compat_local_irq0,
    // Link to the processor
    ccrsm_link_if.host link
);
    // Sequencer states
    typedef enum logic [2:0] {
        ST_HOLD = 3'b001, // Both resets low, code on pins
        ST_GAP = 3'b010, // System reset released, code still held
        ST_RUN = 3'b100 // Pins carry compatibility signals
    } ccrsm_state_t;

    ccrsm_state_t state_r; // Sequencer state
    logic [CNT_W-1:0] cnt_r; // Phase down-counter
    logic [3:0] compat_s; // Synchronised compatibility inputs
    logic [3:0] req_code_r; // Code software asked for
    logic [3:0] app_code_r; // Code of the current sequence
    logic [CNT_W-1:0] hold_r; // Reset hold length in cycles, minus one
    logic [CNT_W-1:0] gap_r; // Release gap length in cycles, minus one
    logic bad_r; // Sticky: unsupported code written
    logic go_r; // Sequence start pulse
    logic rst_n_r; // System reset to processor
    logic crst_n_r; // CMOS reset to multiplexer
    logic [3:0] pins_r; // Ratio pin levels
    logic pready_r; // APB ready
    logic pslverr_r; // APB error
    logic [31:0] prdata_r; // APB read data
    logic acc; // Access phase
    logic commit; // Access completes this edge
    logic hit; // Address maps to a register
    logic [31:0] rdata; // Read mux
    logic wr_ctrl; // Write to control
    logic wr_stat; // Write to status
    logic [3:0] wcode; // Code field of the write

    // Compatibility inputs come from another domain
    ccrsm_sync #(
        .W(4)
    ) u_compat_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d({compat_local_irq1, compat_local_irq0,
            compat_addr20_mask, compat_ignore_numeric_error}),
        .q(compat_s)
    );

    // APB phase decode
    assign acc = psel && penable;
    assign commit = acc && pready_r;
    assign wcode = pwdata[CTRL_CODE_LSB +: CODE_W];
    assign wr_ctrl = commit && pwrite && (paddr == REG_CTRL);
    assign wr_stat = commit && pwrite && (paddr == REG_STATUS);

    // Read mux and address decode
    always_comb begin
        rdata = 32'h0000_0000;
        hit = 1'b1;
        case (paddr)
            REG_CTRL: begin
                rdata[CTRL_CODE_LSB +: CODE_W] = req_code_r;
            end
            REG_STATUS: begin
                rdata[STAT_CODE_LSB +: CODE_W] = app_code_r;
                rdata[STAT_RST_BIT] = !rst_n_r;
                rdata[STAT_CRST_BIT] = !crst_n_r;
                rdata[STAT_BUSY_BIT] = (state_r != ST_RUN);
                rdata[STAT_BAD_BIT] = bad_r;
            end
            REG_HOLD: begin
                rdata[CNT_W-1:0] = hold_r;
            end
            REG_GAP: begin
                rdata[CNT_W-1:0] = gap_r;
            end
            default: begin
                // Unmapped: zero data and an error
                hit = 1'b0;
            end
        endcase
    end

    // One wait state: ready in the second access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
        end else begin
            pready_r <= acc && !pready_r;
        end
    end

    // Read data and error loaded with ready
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else if (acc && !pready_r) begin
            prdata_r <= pwrite ? 32'h0000_0000 : rdata;
            pslverr_r <= !hit;
        end else begin
            pslverr_r <= 1'b0;
        end
    end

    // Requested code: only validated codes are kept
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_code_r <= CTRL_CODE_RST;
        end else if (wr_ctrl && ccrsm_supported(wcode)) begin
            req_code_r <= wcode;
        end
    end

    // Sticky bad-code flag, set beats clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bad_r <= 1'b0;
        end else begin
            bad_r <= (wr_ctrl && !ccrsm_supported(wcode))
                || (bad_r && !(wr_stat && pwdata[STAT_BAD_BIT]));
        end
    end

    // Phase lengths
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_r <= HOLD_RST;
            gap_r <= GAP_RST;
        end else if (commit && pwrite) begin
            if (paddr == REG_HOLD) begin
                hold_r <= pwdata[CNT_W-1:0];
            end
            if (paddr == REG_GAP) begin
                gap_r <= pwdata[CNT_W-1:0];
            end
        end
    end

    // Start request, ignored while a sequence runs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            go_r <= 1'b0;
        end else begin
            go_r <= wr_ctrl && pwdata[CTRL_GO_BIT] && (state_r == ST_RUN);
        end
    end

    // Reset sequencer; power-up starts in the hold phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_HOLD;
            cnt_r <= HOLD_RST;
            app_code_r <= CTRL_CODE_RST;
            rst_n_r <= 1'b0;
            crst_n_r <= 1'b0;
        end else begin
            unique case (state_r)
                ST_HOLD: begin
                    if (cnt_r == '0) begin
                        // Processor latches code here
                        rst_n_r <= 1'b1;
                        cnt_r <= gap_r;
                        state_r <= ST_GAP;
                    end else begin
                        cnt_r <= cnt_r - 1'b1;
                    end
                end
                ST_GAP: begin
                    if (cnt_r == '0) begin
                        // Hand pins back after reset release
                        crst_n_r <= 1'b1;
                        state_r <= ST_RUN;
                    end else begin
                        cnt_r <= cnt_r - 1'b1;
                    end
                end
                ST_RUN: begin
                    if (go_r) begin
                        // New code taken only with both resets low
                        app_code_r <= req_code_r;
                        rst_n_r <= 1'b0;
                        crst_n_r <= 1'b0;
                        cnt_r <= hold_r;
                        state_r <= ST_HOLD;
                    end
                end
                default: begin
                    state_r <= ST_HOLD;
                    cnt_r <= hold_r;
                    rst_n_r <= 1'b0;
                    crst_n_r <= 1'b0;
                end
            endcase
        end
    end

    // Pin multiplexer steered by CMOS reset, registered on the bus clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pins_r <= CTRL_CODE_RST;
        end else if (crst_n_r) begin
            pins_r <= compat_s;
        end else begin
            // Compatibility inputs fully ignored here
            pins_r <= app_code_r;
        end
    end

    // Code stays put inside a reset sequence
    assign link.local_irq1_pin = pins_r[CODE_LINT1_BIT];
    // One pin set may feed every processor, so all share one ratio
    assign link.local_irq0_pin = pins_r[CODE_LINT0_BIT];
    assign link.addr20_mask_pin = pins_r[CODE_ADDR20_MASK_PIN_BIT];
    assign link.ignore_numeric_error_pin = pins_r[CODE_IGNORE_NUMERIC_ERROR_PIN_BIT];
    assign link.sys_reset_n = rst_n_r;
    assign link.cmos_reset_n = crst_n_r;
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
endmodule : ccrsm_host

// ==== dv/ccrsm_link_asserts.sv ====
// Purpose: Concurrent checks on the link between system end and processor end
// Assumes: Instantiated beside the link interface, all signals on pclk
// Notes: Hold programmed to at least 3 and gap to at least 1 by the bench
`timescale 1ns/10ps
module ccrsm_link_asserts
    import ccrsm_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Link signals
    input wire logic sys_reset_n,
    input wire logic cmos_reset_n,
    input wire logic addr20_mask_pin,
    input wire logic ignore_numeric_error_pin,
    input wire logic local_irq1_pin,
    input wire logic local_irq0_pin
);
    // Longest gap the bench programs, plus margin
    localparam int GAP_MAX = 20;
    // Ratio code as the processor reads it
    logic [3:0] pins_w;
    assign pins_w = {local_irq1_pin, local_irq0_pin, addr20_mask_pin, ignore_numeric_error_pin};

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_PWRUP_SAFE: assert property (
        $rose(presetn) |-> !sys_reset_n && !cmos_reset_n && pins_w == CODE_QUARTER)
        else $error("Link not in safe reset state after power-up");
    AST_SYS_INSIDE_CRST: assert property (!sys_reset_n |-> !cmos_reset_n)
        else $error("System reset active without CMOS reset");
    AST_BOTH_FALL: assert property ($fell(sys_reset_n) |-> $fell(cmos_reset_n))
        else $error("Resets did not fall together");
    AST_HOLD_MIN: assert property ($fell(sys_reset_n) |-> !sys_reset_n [*4])
        else $error("System reset hold too short");
    AST_CODE_FROZEN_HOLD: assert property (
        !sys_reset_n && !$past(sys_reset_n) && !$past(sys_reset_n, 2) |-> $stable(pins_w))
        else $error("Ratio pins moved inside reset hold");
    AST_CODE_FROZEN_GAP: assert property (
        sys_reset_n && !cmos_reset_n |-> $stable(pins_w))
        else $error("Ratio pins moved after system reset release");
    AST_SUPPORTED_AT_RELEASE: assert property (
        $rose(sys_reset_n) |-> pins_w == CODE_QUARTER || pins_w == CODE_TWO_NINTHS)
        else $error("Unsupported ratio code at reset release");
    AST_CRST_GAP: assert property (
        $rose(sys_reset_n) |-> !cmos_reset_n ##1 !cmos_reset_n ##[1:GAP_MAX] cmos_reset_n)
        else $error("CMOS reset gap wrong");
endmodule : ccrsm_link_asserts

// ==== dv/testbench.sv ====
// Purpose: Self-checking bench for system end and processor end joined by the link
// Assumes: APB answers with one wait state
// Notes: Each scenario is its own task and judges its results
`timescale 1ns/10ps
module testbench;
    import ccrsm_pkg::*;
    // Clock, reset and APB
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic err;
    // Chipset compatibility signals
    logic [3:0] compat;
    // Processor end outputs
    logic [3:0] core_ratio_code, core_mult_num, core_mult_den;
    logic core_ratio_supported, core_ratio_valid, core_in_reset;
    // Result counters
    int miscompares = 0;
    int n_compared = 0;

    ccrsm_link_if ccrsm_link_if_inst ();
    ccrsm_host ccrsm_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .compat_addr20_mask(compat[1]), .compat_ignore_numeric_error(compat[0]),
        .compat_local_irq1(compat[3]), .compat_local_irq0(compat[2]), .link(ccrsm_link_if_inst));
    ccrsm_dev ccrsm_dev_inst (.pclk(pclk), .presetn(presetn), .link(ccrsm_link_if_inst),
        .core_ratio_code(core_ratio_code), .core_mult_num(core_mult_num),
        .core_mult_den(core_mult_den), .core_ratio_supported(core_ratio_supported),
        .core_ratio_valid(core_ratio_valid), .core_in_reset(core_in_reset));
    ccrsm_link_asserts ccrsm_link_asserts_inst (.pclk(pclk), .presetn(presetn),
        .sys_reset_n(ccrsm_link_if_inst.sys_reset_n),
        .cmos_reset_n(ccrsm_link_if_inst.cmos_reset_n),
        .addr20_mask_pin(ccrsm_link_if_inst.addr20_mask_pin),
        .ignore_numeric_error_pin(ccrsm_link_if_inst.ignore_numeric_error_pin),
        .local_irq1_pin(ccrsm_link_if_inst.local_irq1_pin),
        .local_irq0_pin(ccrsm_link_if_inst.local_irq0_pin));

    // Bus clock, 40 ns period
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // Prints counts and the verdict, then ends the run
    task give_verdict;
        $display("Compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : give_verdict

    // Compares one value against its expectation
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer; holds the request until pready is sampled high
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Ends once pready is sampled high; the watchdog ends a hang
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Polls status until no reset sequence is running
    task wait_idle;
        do begin
            apb(1'b0, REG_STATUS, 32'h0);
        end while (rd[STAT_BUSY_BIT] !== 1'b0);
    endtask : wait_idle

    // Checks what the processor end captured
    task check_dev(input logic [3:0] code, input logic [3:0] num, input logic [3:0] den);
        chk(core_ratio_code, code);
        chk(core_mult_num, num);
        chk(core_mult_den, den);
        chk(core_ratio_supported, 1'b1);
        chk(core_ratio_valid, 1'b1);
        chk(core_in_reset, 1'b0);
    endtask : check_dev

    // Power-up sequence drives the safe code, registers hold reset values
    task t_power_up;
        wait_idle();
        check_dev(CODE_QUARTER, 4'h1, 4'h4);
        chk(rd & 32'h0000070f, 32'h00000002);
        apb(1'b0, REG_CTRL, 32'h0);
        chk(rd, 32'(CTRL_CODE_RST));
        apb(1'b0, REG_HOLD, 32'h0);
        chk(rd, 32'(HOLD_RST));
        apb(1'b0, REG_GAP, 32'h0);
        chk(rd, 32'(GAP_RST));
        apb(1'b0, 8'h10, 32'h0);
        chk(err, 1'b1);
        chk(rd, 32'h0);
    endtask : t_power_up

    // Compatibility levels pass to the pins after the sequence
    task t_passthru(input logic [3:0] v);
        compat <= v;
        repeat (5) @(posedge pclk);
        chk({ccrsm_link_if_inst.local_irq1_pin, ccrsm_link_if_inst.local_irq0_pin,
             ccrsm_link_if_inst.addr20_mask_pin, ccrsm_link_if_inst.ignore_numeric_error_pin},
            v);
    endtask : t_passthru

    // Reset sequence with a new code while compatibility inputs toggle
    task t_go(input logic [3:0] code, input logic [3:0] num, input logic [3:0] den);
        apb(1'b1, REG_HOLD, 32'h0000000a);
        apb(1'b1, REG_GAP, 32'h00000001);
        compat <= ~code;
        apb(1'b1, REG_CTRL, 32'h00010000 | code);
        repeat (7) @(posedge pclk);
        chk(core_in_reset, 1'b1);
        chk(core_ratio_valid, 1'b0);
        compat <= code ^ 4'h5;
        wait_idle();
        chk(rd[3:0], code);
        check_dev(code, num, den);
        t_passthru(4'h9);
        chk(core_ratio_code, code);
    endtask : t_go

    // Unsupported codes are refused and flagged, flag clears on write
    task t_refuse;
        logic [3:0] last;
        last = CODE_QUARTER;
        for (int c = 0; c < 16; c++) begin
            apb(1'b1, REG_CTRL, 32'(c));
            if (c == 2 || c == 6) begin
                last = 4'(c);
            end
            apb(1'b0, REG_CTRL, 32'h0);
            chk(rd[3:0], last);
        end
        apb(1'b0, REG_STATUS, 32'h0);
        chk(rd[STAT_BAD_BIT], 1'b1);
        apb(1'b1, REG_STATUS, 32'h00010000);
        apb(1'b0, REG_STATUS, 32'h0);
        chk(rd[STAT_BAD_BIT], 1'b0);
    endtask : t_refuse

    // Main sequence
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        compat = 4'h0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_power_up();
        t_passthru(4'h6);
        t_go(CODE_TWO_NINTHS, 4'h2, 4'h9);
        t_go(CODE_QUARTER, 4'h1, 4'h4);
        t_refuse();
        give_verdict();
    end

    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        give_verdict();
    end
endmodule : testbench
